// file: design/ufc_uart.sv
// serial port control: registers, fifos, interrupt id, line format, loopback
`timescale 1ns/1ps
module ufc_uart
    import ufc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [2:0]  wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    output logic      [7:0]  wb_dat_o,
    output logic             wb_ack_o,
    // serial line
    input  wire logic        rxd,
    output logic             txd,
    // handshake pins
    input  wire logic        clear_to_send_n,
    input  wire logic        data_set_ready_n,
    input  wire logic        ring_indicator_n,
    input  wire logic        carrier_detect_n,
    output logic             terminal_ready_n,
    output logic             request_to_send_n,
    // interrupt pin, tri-state as output plus enable (low drives)
    output logic             irq_o,
    output logic             irq_oe_n
);
    logic [7:0]  line_format_control;
    logic [4:0]  handshake_control;
    logic [3:0]  int_enable;
    logic [7:0]  scratch;
    logic [15:0] divisor;
    logic        fifo_en;
    logic [1:0]  trig_sel;
    logic [7:0]  thr_fifo [FIFO_DEPTH];
    ufc_rx_entry_t rx_fifo [FIFO_DEPTH];
    logic [3:0]  tx_wp, tx_rp, rx_wp, rx_rp;
    logic [4:0]  tx_cnt, rx_cnt;
    logic [3:0]  lstat_err;   // overrun, parity, framing, break
    logic [3:0]  hs_delta;
    logic [3:0]  hs_prev;
    logic        thre_int;
    logic [7:0]  ident_frz;
    logic        ack_d;
    logic        rx_s1, rx_s2, rx_s3;
    logic [3:0]  hp_q;  // filtered handshake levels
    logic [3:0]  hp_s1, hp_s2, hp_s3;

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'b00:   trig_level = 5'd1;
            2'b01:   trig_level = 5'd4;
            2'b10:   trig_level = 5'd8;
            default: trig_level = 5'd14;  // [RQ11]
        endcase
    endfunction

    function automatic logic [3:0] data_bits(input logic [1:0] wl);
        data_bits = 4'd5 + {2'b00, wl};  // [RQ12]
    endfunction

    wire logic bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wr       = bus_req & wb_we_i;
    wire logic rd       = bus_req & ~wb_we_i;
    wire logic divisor_latch_select     = line_format_control[7];
    wire logic loop     = handshake_control[4];
    wire logic rd_buf   = rd & wb_adr_i == OFS_DATA & ~divisor_latch_select;  // [RQ19]
    wire logic wr_thr   = wr & wb_adr_i == OFS_DATA & ~divisor_latch_select;
    wire logic wr_fcr   = wr & wb_adr_i == OFS_IDENT;  // [RQ5]
    wire logic rd_ident = rd & wb_adr_i == OFS_IDENT;
    wire logic rd_lstat = rd & wb_adr_i == OFS_LSTAT;
    wire logic rd_hstat = rd & wb_adr_i == OFS_HSTAT;

    // baud tick at 16x from divisor; one-cycle enable
    logic [15:0] baud_cnt;
    logic        tick;
    always_ff @(posedge sys_clk) begin
        tick <= 1'b0;
        if (sys_rst || (wr && divisor_latch_select && wb_adr_i <= OFS_IEN)) begin
            baud_cnt <= '0;  // reload immediately on latch write
        end else if (baud_cnt + 16'h1 >= divisor || divisor == '0) begin
            baud_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + 16'h1;
        end
    end

    // software registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            line_format_control <= LINE_RESET;
            handshake_control   <= HSC_RESET;
            int_enable          <= '0;
            scratch             <= '0;
            divisor             <= DIV_RESET;
            fifo_en             <= 1'b0;
            trig_sel            <= '0;
        end else if (wr) begin
            case (wb_adr_i)
                OFS_DATA:  if (divisor_latch_select) divisor[7:0] <= wb_dat_i;  // [RQ19]
                OFS_IEN:   if (divisor_latch_select) divisor[15:8] <= wb_dat_i; else int_enable <= wb_dat_i[3:0];
                OFS_IDENT: begin
                    fifo_en <= wb_dat_i[0];  // [RQ6]
                    // other bits only take effect with enable set; dma bit dropped
                    if (wb_dat_i[0]) trig_sel <= wb_dat_i[7:6];  // [RQ7] [RQ9]
                end
                OFS_LINE:  line_format_control <= wb_dat_i;
                OFS_HSC:   handshake_control <= wb_dat_i[4:0];  // [RQ21]
                OFS_SCR:   scratch <= wb_dat_i;
                default:   ;
            endcase
        end
    end

    wire logic rx_flush = wr_fcr & (~wb_dat_i[0] | wb_dat_i[1]);  // [RQ8] [RQ6]
    wire logic tx_flush = wr_fcr & (~wb_dat_i[0] | wb_dat_i[2]);  // [RQ8] [RQ6]
    wire logic [4:0] depth = fifo_en ? 5'd16 : 5'd1;

    // transmitter: holding fifo plus shift engine
    ufc_state_t  tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_left, tx_os;
    logic        tx_half, tx_line;
    wire logic   tx_pop = tx_st == UFC_IDLE && tx_cnt != '0;
    wire logic   par_bit_tx = line_format_control[5] ? ~line_format_control[4] :  // [RQ17]
                              ^thr_fifo[tx_rp] ^ ~line_format_control[4];        // [RQ16]
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_st <= UFC_IDLE; tx_line <= 1'b1; tx_left <= '0; tx_os <= '0; tx_half <= 1'b0;
            tx_sh <= '1;
        end else if (tx_pop) begin
            // frame: data, optional parity, stop bits; start sent first
            tx_sh   <= {3'b111, (thr_fifo[tx_rp] & (8'hff >> (4'd8 - data_bits(line_format_control[1:0]))))};
            if (line_format_control[3]) tx_sh[data_bits(line_format_control[1:0])] <= par_bit_tx;  // [RQ15]
            tx_left <= data_bits(line_format_control[1:0]) + {3'b000, line_format_control[3]};
            tx_half <= line_format_control[2] && line_format_control[1:0] == 2'b00;  // [RQ13]
            tx_line <= 1'b0;
            tx_os   <= '0;
            tx_st   <= UFC_BITS;
        end else if (tick && tx_st != UFC_IDLE) begin
            tx_os <= tx_os + 4'h1;
            if (tx_st == UFC_STOP && tx_half && tx_left == 4'h1 && tx_os == 4'h7) begin
                tx_st <= UFC_IDLE;  // half stop done
            end else if (tx_os == OVERSAMPLE) begin
                case (tx_st)
                    UFC_BITS: begin
                        tx_line <= tx_sh[0];
                        tx_sh   <= {1'b1, tx_sh[10:1]};
                        if (tx_left == 4'h1) tx_st <= UFC_START;
                        tx_left <= tx_left - 4'h1;
                    end
                    UFC_START: begin
                        tx_line <= 1'b1;  // first stop bit, held a full bit time
                        tx_st   <= UFC_STOP;
                        tx_left <= line_format_control[2] ? 4'h2 : 4'h1;  // [RQ13]
                    end
                    UFC_STOP:  if (tx_left == 4'h1) tx_st <= UFC_IDLE; else tx_left <= tx_left - 4'h1;
                    default:   tx_st <= UFC_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || tx_flush) begin
            tx_wp <= '0; tx_rp <= '0; tx_cnt <= '0;  // [RQ8]
        end else begin
            if (wr_thr && tx_cnt < depth) begin
                thr_fifo[tx_wp] <= wb_dat_i;
                tx_wp <= tx_wp + 4'h1;
            end
            if (tx_pop) tx_rp <= tx_rp + 4'h1;
            tx_cnt <= tx_cnt + {4'h0, wr_thr && tx_cnt < depth} - {4'h0, tx_pop};
        end
    end

    // receiver input: 3-stage sync, change accepted when stages 2 and 3 agree
    logic rx_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_s1 <= '1; rx_s2 <= '1; rx_s3 <= '1; rx_q <= 1'b1;
            hp_s1 <= '1; hp_s2 <= '1; hp_s3 <= '1; hp_q <= '1;
        end else begin
            rx_s1 <= rxd; rx_s2 <= rx_s1; rx_s3 <= rx_s2;
            hp_s1 <= {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n};
            hp_s2 <= hp_s1; hp_s3 <= hp_s2;
            if (rx_s2 == rx_s3) rx_q <= rx_s3;
            if (hp_s2 == hp_s3) hp_q <= hp_s3;
        end
    end

    wire logic rx_in = loop ? tx_line : rx_q;  // [RQ23]

    // receiver engine
    ufc_state_t  rx_st;
    logic [3:0]  rx_os, rx_left;
    logic [8:0]  rx_sh;
    logic        rx_zero, rx_push;
    ufc_rx_entry_t rx_word;
    wire logic [3:0] rx_bits = data_bits(line_format_control[1:0]) + {3'b000, line_format_control[3]};
    always_ff @(posedge sys_clk) begin
        rx_push <= 1'b0;
        if (sys_rst) begin
            rx_st <= UFC_IDLE; rx_os <= '0; rx_left <= '0; rx_sh <= '0; rx_zero <= 1'b0; rx_word <= '0;
        end else if (tick) begin
            rx_os <= rx_os + 4'h1;
            case (rx_st)
                UFC_IDLE: begin
                    rx_os <= '0;
                    if (!rx_in) rx_st <= UFC_START;
                end
                UFC_START: if (rx_os == 4'h7) begin
                    rx_os <= '0;
                    rx_st <= rx_in ? UFC_IDLE : UFC_BITS;
                    rx_left <= rx_bits; rx_zero <= 1'b1; rx_sh <= '0;
                end
                UFC_BITS: if (rx_os == OVERSAMPLE) begin
                    rx_sh   <= {rx_in, rx_sh[8:1]};
                    rx_zero <= rx_zero & ~rx_in;
                    rx_left <= rx_left - 4'h1;
                    if (rx_left == 4'h1) rx_st <= UFC_STOP;
                end
                UFC_STOP: if (rx_os == OVERSAMPLE) begin
                    // only the first stop bit is sampled, extra stops look idle
                    rx_st <= UFC_IDLE;  // [RQ14]
                    rx_push <= 1'b1;
                    rx_word.dat <= 8'(rx_sh >> (4'd9 - rx_bits)) & (8'hff >> (4'd8 - data_bits(line_format_control[1:0])));
                    rx_word.par_err <= line_format_control[3] &&  // [RQ15]
                        (line_format_control[5] ? rx_sh[8] != ~line_format_control[4] :  // [RQ17]
                         (^(rx_sh >> (4'd9 - rx_bits))) != ~line_format_control[4]);  // [RQ16]
                    rx_word.frm_err <= ~rx_in;
                    rx_word.brk <= rx_zero & ~rx_in;
                end
                default: rx_st <= UFC_IDLE;
            endcase
        end
    end

    // receive fifo and character-time idle counter
    logic [9:0] idle_cnt;  // counts ticks; receiver holds rx_os at zero while idle
    wire logic  rx_full = rx_cnt >= depth;
    wire logic  rx_pop  = rd_buf && rx_cnt != '0;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || rx_flush) begin
            rx_wp <= '0; rx_rp <= '0; rx_cnt <= '0;  // [RQ8] [RQ6]
        end else begin
            if (rx_push && !rx_full) begin
                rx_fifo[rx_wp] <= rx_word;
                rx_wp <= rx_wp + 4'h1;
            end
            if (rx_pop) rx_rp <= rx_rp + 4'h1;
            rx_cnt <= rx_cnt + {4'h0, rx_push && !rx_full} - {4'h0, rx_pop};
        end
    end

    wire logic [9:0] tmo_limit = 10'(TMO_CHARS * (32'd1 + OVERSAMPLE) * (32'd3 + rx_bits));
    always_ff @(posedge sys_clk) begin
        if (sys_rst || rx_push || rx_pop || rx_cnt == '0) idle_cnt <= '0;
        else if (tick && idle_cnt != tmo_limit) idle_cnt <= idle_cnt + 10'h1;
    end
    wire logic tmo_pend = fifo_en && rx_cnt != '0 && idle_cnt == tmo_limit;  // [RQ4]

    // line status errors: set wins over clear on the read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) lstat_err <= '0;
        else lstat_err <= (rd_lstat ? 4'h0 : lstat_err) |  // [RQ3]
            {rx_push & rx_word.brk, rx_push & rx_word.frm_err, rx_push & rx_word.par_err, rx_push & rx_full};
    end

    // handshake status, loopback sources from control bits
    wire logic [3:0] hs_now = loop ? {handshake_control[3], handshake_control[2],
                                      handshake_control[0], handshake_control[1]} : ~hp_q;  // [RQ25] [RQ24]
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hs_prev <= '0; hs_delta <= '0;
        end else begin
            hs_prev <= hs_now;
            hs_delta <= (rd_hstat ? 4'h0 : hs_delta) |  // [RQ3]
                {hs_prev[3] ^ hs_now[3], hs_prev[2] & ~hs_now[2], hs_prev[1:0] ^ hs_now[1:0]};
        end
    end

    // transmit-empty interrupt: set on emptying, cleared by id read naming it or holding register write
    wire logic thr_empty = tx_cnt == '0;
    logic thr_empty_d;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            thr_empty_d <= 1'b1; thre_int <= 1'b0;
        end else begin
            thr_empty_d <= thr_empty;
            if ((thr_empty && !thr_empty_d) || (wr && wb_adr_i == OFS_IEN && !divisor_latch_select && wb_dat_i[1] && thr_empty))
                thre_int <= 1'b1;
            else if (wr_thr || (rd_ident && ident_frz[3:0] == ID_THRE)) thre_int <= 1'b0;  // [RQ3]
        end
    end

    // priority encode
    wire logic data_pend = int_enable[0] && rx_cnt >= (fifo_en ? trig_level(trig_sel) : 5'd1);  // [RQ3]
    logic [3:0] id_code;
    always_comb begin
        if (int_enable[2] && lstat_err != '0)         id_code = ID_LINE;
        else if (data_pend)                           id_code = ID_DATA;
        else if (int_enable[0] && tmo_pend)           id_code = ID_TMO;
        else if (int_enable[1] && thre_int)           id_code = ID_THRE;
        else if (int_enable[3] && hs_delta != '0)     id_code = ID_MODEM;  // [RQ24]
        else                                          id_code = ID_NONE;  // [RQ2]
    end

    // identification snapshot, held while host read in progress
    always_ff @(posedge sys_clk) begin
        if (sys_rst) ident_frz <= {4'h0, ID_NONE};
        else if (!(wb_cyc_i && wb_stb_i && wb_adr_i == OFS_IDENT && !wb_we_i))
            ident_frz <= {{2{fifo_en}}, 2'b00, id_code};  // [RQ26] [RQ1] [RQ10]
    end

    // read mux and single-wait-state ack
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0; wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            if (rd) begin
                case (wb_adr_i)
                    OFS_DATA:  wb_dat_o <= divisor_latch_select ? divisor[7:0] : rx_fifo[rx_rp].dat;
                    OFS_IEN:   wb_dat_o <= divisor_latch_select ? divisor[15:8] : {4'h0, int_enable};
                    OFS_IDENT: wb_dat_o <= ident_frz;
                    OFS_LINE:  wb_dat_o <= line_format_control;
                    OFS_HSC:   wb_dat_o <= {3'b000, handshake_control};
                    OFS_LSTAT: wb_dat_o <= {1'b0, thr_empty && tx_st == UFC_IDLE, thr_empty, lstat_err, rx_cnt != '0};
                    OFS_HSTAT: wb_dat_o <= {hs_now, hs_delta};
                    default:   wb_dat_o <= scratch;
                endcase
            end
        end
    end

    // pin outputs, registered
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txd <= 1'b1; terminal_ready_n <= 1'b1; request_to_send_n <= 1'b1;
            irq_o <= 1'b0; irq_oe_n <= 1'b1;
        end else begin
            txd <= line_format_control[6] ? 1'b0 : (loop ? 1'b1 : tx_line);  // [RQ18] [RQ23]
            terminal_ready_n  <= loop | ~handshake_control[0];  // [RQ20] [RQ23]
            request_to_send_n <= loop | ~handshake_control[1];  // [RQ20]
            irq_o    <= id_code != ID_NONE;
            irq_oe_n <= ~handshake_control[3] | loop;  // [RQ22]
        end
    end
endmodule

// file: common/ufc_pkg.sv
// constants and types for the serial port control block
// Function
// [RQ1] identification bits 7:6 read ones while fifo mode is enabled
// [RQ2] identification code per highest pending source, none reads 0001
// [RQ3] each pending source clears on its own documented read or write
// [RQ4] timeout raised when fifo non-empty and idle for four character times
// [RQ5] write to offset 2 is fifo control, read is identification, any latch select
// [RQ6] fifo enable bit set enables both fifos; clearing disables and empties them
// [RQ7] host writes enable bit one whenever it writes other fifo control bits
// [RQ8] flush bits empty the chosen fifo and clear themselves
// [RQ9] dma mode bit ignored, no dma request outputs
// [RQ10] bits 5:4 of identification and fifo control are reserved, read zero
// [RQ11] receive trigger level 1, 4, 8 or 14 bytes from bits 7:6
// [RQ12] line control bits 1:0 select 5 to 8 data bits
// [RQ13] stop select gives 1, 1.5 for 5-bit or 2 stop bits
// [RQ14] receiver checks only the first stop bit
// [RQ15] parity enable inserts and checks a parity bit before the stop bit
// [RQ16] parity type bit selects odd when clear, even when set
// [RQ17] stick parity sends and expects the inverse of the parity type bit
// [RQ18] break bit forces transmit line low until cleared
// [RQ19] divisor latch select maps offsets 0 and 1 to divisor latches
// [RQ20] terminal ready and request to send pins are inverse of control bits 0, 1
// [RQ21] handshake control bit 2 is plain storage with no pin
// [RQ22] interrupt output released unless gate bit 3 is set
// [RQ23] loopback idles transmit at mark, loops data and handshake lines, pins inactive
// [RQ24] in loopback status interrupts come from control bits, still enabled per source
// [RQ25] in loopback status bits 7:4 follow the control bits
// [RQ26] identification value frozen while the host read is in progress
package ufc_pkg;
    localparam logic [2:0] OFS_DATA  = 3'h0;
    localparam logic [2:0] OFS_IEN   = 3'h1;
    localparam logic [2:0] OFS_IDENT = 3'h2;
    localparam logic [2:0] OFS_LINE  = 3'h3;
    localparam logic [2:0] OFS_HSC   = 3'h4;
    localparam logic [2:0] OFS_LSTAT = 3'h5;
    localparam logic [2:0] OFS_HSTAT = 3'h6;
    localparam logic [2:0] OFS_SCR   = 3'h7;
    localparam logic [7:0] LINE_RESET = 8'h00;
    localparam logic [4:0] HSC_RESET  = 5'h00;
    localparam logic [3:0] ID_NONE  = 4'h1;
    localparam logic [3:0] ID_LINE  = 4'h6;
    localparam logic [3:0] ID_DATA  = 4'h4;
    localparam logic [3:0] ID_TMO   = 4'hc;
    localparam logic [3:0] ID_THRE  = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;
    localparam int FIFO_DEPTH = 16;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [3:0] OVERSAMPLE = 4'hf;
    localparam int TMO_CHARS = 4;

    typedef struct packed {
        logic [7:0] dat;
        logic       par_err;
        logic       frm_err;
        logic       brk;
    } ufc_rx_entry_t;

    typedef enum logic [1:0] { UFC_IDLE, UFC_START, UFC_BITS, UFC_STOP } ufc_state_t;
endpackage

// file: testbench/ufc_sva.sv
// assertion checker for the serial port control block
`timescale 1ns/1ps
module ufc_sva
    import ufc_pkg::*;
(
    // clock, reset and bus
    input wire logic       sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [2:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i, wb_dat_o,
    input wire logic       wb_ack_o,
    // serial, handshake and interrupt pins
    input wire logic       rxd, txd, clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n,
    input wire logic       terminal_ready_n, request_to_send_n, irq_o, irq_oe_n
);
    logic [7:0] lcr_sh;
    logic [4:0] hsc_sh;
    logic       fen_sh;
    logic       rd_id;
    logic [1:0] age;
    logic       take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // shadow copies of control writes; age lets registered pins settle first
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lcr_sh <= 8'h00;
            hsc_sh <= 5'h00;
            fen_sh <= 1'b0;
            age    <= 2'h0;
        end else if (take && wb_we_i && wb_adr_i inside {OFS_IDENT, OFS_LINE, OFS_HSC}) begin
            if (wb_adr_i == OFS_LINE) lcr_sh <= wb_dat_i;
            if (wb_adr_i == OFS_HSC) hsc_sh <= wb_dat_i[4:0];
            if (wb_adr_i == OFS_IDENT) fen_sh <= wb_dat_i[0];
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    // marks the answer cycle of an identification read
    always_ff @(posedge sys_clk) begin
        rd_id <= !sys_rst && take && !wb_we_i && wb_adr_i == OFS_IDENT;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
    ack_timing_a: assert property (take_s |=> ack_s)
        else $error("ack not a single pulse one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    id_fifo_a: assert property (rd_id |-> wb_ack_o && wb_dat_o[7:4] == {{2{fen_sh}}, 2'b00})
        else $error("identification top bits wrong");
    id_code_a: assert property (rd_id |-> wb_dat_o[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
        else $error("identification code illegal");
    break_low_a: assert property (age == 2'h3 && lcr_sh[6] && !hsc_sh[4] |-> !txd)
        else $error("break not holding line low");
    loop_mark_a: assert property (age == 2'h3 && hsc_sh[4] && !lcr_sh[6] |-> txd)
        else $error("loopback line not at mark");
    dtr_pin_a: assert property (age == 2'h3 |-> terminal_ready_n == (hsc_sh[4] || !hsc_sh[0]))
        else $error("terminal ready pin wrong");
    rts_pin_a: assert property (age == 2'h3 |-> request_to_send_n == (hsc_sh[4] || !hsc_sh[1]))
        else $error("request to send pin wrong");
    irq_gate_a: assert property (age == 2'h3 |-> irq_oe_n == !(hsc_sh[3] && !hsc_sh[4]))
        else $error("interrupt output gate wrong");
endmodule
bind ufc_uart ufc_sva ufc_sva_i (.*);

// file: testbench/ufc_term.sv
// far-side terminal model: serial frames into rxd and handshake levels
`timescale 1ns/1ps
module ufc_term #(
    parameter int BIT_CLKS = 80
) (
    // clock of the bench
    input  wire logic sys_clk,
    // lines toward the port
    output logic      rxd,
    output logic      clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n
);
    logic [3:0] hs_lvl = 4'hf; // carrier, ring, set ready, clear to send
    initial rxd = 1'b1; // idle mark
    assign {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n} = hs_lvl;
    // one frame: start, eight data bits lsb first, optional parity, one stop
    task automatic send(input logic [7:0] d, input logic par_en, input logic par);
        logic b;
        for (int i = 0; i < 11; i++) begin
            b = (i == 0) ? 1'b0 : (i < 9) ? d[i-1] : (i == 9 && par_en) ? par : 1'b1;
            if (i == 10 && !par_en) break;
            @(posedge sys_clk) rxd <= b;
            repeat (BIT_CLKS - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk) rxd <= 1'b1;
    endtask
endmodule

// file: testbench/ufc_uart_tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ufc_uart_tb;
    import ufc_pkg::*;
    localparam int BIT_CLKS = 80; // divisor 5, sixteen ticks a bit
    logic       sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rxd, txd, irq_o, irq_oe_n;
    logic       clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n;
    logic       terminal_ready_n, request_to_send_n;
    logic [2:0] wb_adr_i;
    logic [7:0] wb_dat_i, wb_dat_o, v, w, bq[4];
    logic [15:0] q[$], e;
    int         seed, miscompares, cmp_count;
    ufc_uart ufc_uart_i (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .rxd, .txd, .clear_to_send_n, .data_set_ready_n, .ring_indicator_n, .carrier_detect_n,
        .terminal_ready_n, .request_to_send_n, .irq_o, .irq_oe_n);
    ufc_term #(.BIT_CLKS(BIT_CLKS)) ufc_term_i (.sys_clk, .rxd, .clear_to_send_n, .data_set_ready_n,
        .ring_indicator_n, .carrier_detect_n);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // one classic cycle; waits for ack under a bound
    task automatic wb_go(input logic [2:0] a, input logic we, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        wb_go(a, 1'b1, d);
    endtask
    // expectation noted first, compared by the monitor at ack
    task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
        q.push_back({m, x});
        wb_go(a, 1'b0, 8'h00);
    endtask
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            e = (q.size() > 0) ? q.pop_front() : 16'hffff;
            `CHK(wb_dat_o & e[15:8], e[7:0])
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog well beyond the longest expected run
    initial begin
        #(8 * 90000);
        miscompares++;
        end_of_test();
    end
    initial begin
        seed = 93;
        {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 14'h0};
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(OFS_LINE, 8'h00);
        rd(OFS_IDENT, 8'h01);
        `CHK(irq_oe_n, 1'b1)
        // random line formats read back, break kept off
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'h3f;
            wr(OFS_LINE, v);
            rd(OFS_LINE, v);
        end
        wr(OFS_LINE, 8'h43);
        repeat (2) @(posedge sys_clk);
        `CHK(txd, 1'b0)
        wr(OFS_LINE, 8'h83);
        wr(OFS_DATA, 8'h05);
        wr(OFS_IEN, 8'h00);
        rd(OFS_DATA, 8'h05);
        wr(OFS_LINE, 8'h03);
        repeat (2) @(posedge sys_clk);
        `CHK(txd, 1'b1)
        rd(OFS_IEN, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(OFS_HSC, 8'(i));
            rd(OFS_HSC, 8'(i), 8'h1f);
            `CHK({terminal_ready_n, request_to_send_n, irq_oe_n}, ~{i[0], i[1], i[3]})
        end
        @(posedge sys_clk) ufc_term_i.hs_lvl <= 4'h6;
        repeat (8) @(posedge sys_clk);
        rd(OFS_HSTAT, 8'h90, 8'hf0);
        // transmit-empty interrupt, cleared by reading the id
        wr(OFS_IEN, 8'h02);
        repeat (3) @(posedge sys_clk);
        `CHK(irq_o, 1'b1)
        rd(OFS_IDENT, 8'h02);
        rd(OFS_IDENT, 8'h01);
        // fifo mode, parity even, good then bad parity
        wr(OFS_IEN, 8'h05);
        wr(OFS_IDENT, 8'h01);
        wr(OFS_LINE, 8'h1b);
        v = 8'($random(seed));
        w = 8'($random(seed));
        ufc_term_i.send(v, 1'b1, ^v);
        repeat (20) @(posedge sys_clk);
        rd(OFS_IDENT, 8'hc4);
        rd(OFS_DATA, v);
        ufc_term_i.send(w, 1'b1, ~^w);
        repeat (20) @(posedge sys_clk);
        rd(OFS_IDENT, 8'hc6);
        rd(OFS_LSTAT, 8'h04, 8'h04);
        rd(OFS_IDENT, 8'hc4);
        rd(OFS_DATA, w);
        rd(OFS_IDENT, 8'hc1);
        for (int t = 0; t < 4; t++) begin
            wr(OFS_IDENT, {2'(t), 6'h39});
            rd(OFS_IDENT, 8'hc0, 8'hf0);
        end
        // trigger four, timeout with one byte
        wr(OFS_IDENT, 8'h47);
        wr(OFS_LINE, 8'h03);
        ufc_term_i.send(v, 1'b0, 1'b0);
        rd(OFS_IDENT, 8'hc1);
        repeat (5000) @(posedge sys_clk);
        rd(OFS_IDENT, 8'hcc);
        rd(OFS_DATA, v);
        rd(OFS_IDENT, 8'hc1);
        for (int i = 0; i < 4; i++) begin
            bq[i] = 8'($random(seed));
            ufc_term_i.send(bq[i], 1'b0, 1'b0);
            repeat (20) @(posedge sys_clk);
            rd(OFS_IDENT, (i == 3) ? 8'hc4 : 8'hc1);
        end
        rd(OFS_DATA, bq[0]);
        rd(OFS_IDENT, 8'hc1);
        wr(OFS_IDENT, 8'h43);
        rd(OFS_LSTAT, 8'h00, 8'h01);
        ufc_term_i.send(v, 1'b0, 1'b0);
        repeat (20) @(posedge sys_clk);
        wr(OFS_IDENT, 8'h00);
        rd(OFS_LSTAT, 8'h00, 8'h01);
        // loopback: pins idle, status from control bits, data returns
        wr(OFS_HSC, 8'h15);
        repeat (2) @(posedge sys_clk);
        `CHK({txd, terminal_ready_n, request_to_send_n, irq_oe_n}, 4'hf)
        rd(OFS_HSTAT, 8'h60, 8'hf0);
        wr(OFS_LINE, 8'h1b);
        wr(OFS_DATA, w);
        repeat (BIT_CLKS * 13) @(posedge sys_clk);
        rd(OFS_DATA, w);
        rd(OFS_LSTAT, 8'h00, 8'h0e);
        end_of_test();
    end
endmodule
